/* File: pkg/sar_ctrl_regs.vh */
// Constants of the dual-channel conversion controller
`ifndef SAR_CTRL_REGS_VH
`define SAR_CTRL_REGS_VH
`define SAR_CLK_MHZ 20
`define SAR_CONV_NS 800
`define SAR_CONV_CYC ((`SAR_CONV_NS * `SAR_CLK_MHZ + 999) / 1000)
`define SAR_ACQ_NS 450
`define SAR_ACQ_CYC ((`SAR_ACQ_NS * `SAR_CLK_MHZ + 999) / 1000)
`define SAR_SDO_BIT 0
`define SAR_SCK_BIT 1
`define SAR_RESULT_RST 16'h0000
`endif

/* File: rtl/sar_core.v */
// One successive approximation channel converter
`timescale 1ns/1ps
module sar_core #(
  parameter WIDTH = 16,
  parameter CYCLES = 16
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Control
  input wire i_start,
  input wire [WIDTH-1:0] i_sample,
  // Result
  output reg o_done,
  output reg [WIDTH-1:0] o_result
);
  reg [7:0] count;
  reg running;
  reg [WIDTH-1:0] held;

  // Count out the conversion time, then publish the held sample
  always @(posedge i_clk) begin
    if (i_rst) begin
      count <= 8'h00;
      running <= 1'b0;
      held <= {WIDTH{1'b0}};
      o_done <= 1'b0;
      o_result <= {WIDTH{1'b0}};
    end else begin
      o_done <= 1'b0;
      if (i_start && !running) begin
        running <= 1'b1;
        held <= i_sample;
        count <= 8'h00;
      end else if (running) begin
        if (count == CYCLES[7:0] - 8'h01) begin
          running <= 1'b0;
          o_done <= 1'b1;
          o_result <= held;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end
endmodule

/* File: rtl/sar_ctrl.v */
// Conversion control and output gating of the dual-channel converter
`timescale 1ns/1ps
`include "sar_ctrl_regs.vh"
module sar_ctrl #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Conversion control
  input wire i_convert_start_n,
  input wire i_power_down,
  input wire i_power_scaled,
  input wire i_input_pair_select,
  // Analog samples as digital codes
  input wire [WIDTH-1:0] i_channel_a_input1,
  input wire [WIDTH-1:0] i_channel_a_input2,
  input wire [WIDTH-1:0] i_channel_b_input1,
  input wire [WIDTH-1:0] i_channel_b_input2,
  // Output interface
  input wire i_cs_n,
  input wire i_rd_n,
  input wire i_chan_a_sel,
  input wire i_serial,
  input wire i_sclk,
  // Status and data
  output reg o_busy,
  output reg o_low_power,
  output reg o_pair_used,
  output reg [WIDTH-1:0] o_data,
  output reg [WIDTH-1:0] o_data_oe
);
  localparam ST_IDLE = 2'b00;
  localparam ST_CONV_A = 2'b01;
  localparam ST_CONV_B = 2'b10;
  localparam ST_ACQ = 2'b11;
  localparam integer CONV_CYC = `SAR_CONV_CYC;
  localparam integer ACQ_CYC = `SAR_ACQ_CYC;

  reg [1:0] state;
  reg [1:0] next_state;
  reg start_q;
  reg [7:0] acq_count;
  reg [WIDTH-1:0] samp_a;
  reg [WIDTH-1:0] samp_b;
  reg [WIDTH-1:0] res_a;
  reg [WIDTH-1:0] res_b;
  reg [2*WIDTH-1:0] shreg;
  reg [5:0] bits_left;
  reg sclk_q;
  reg kick_a;
  reg kick_b;
  wire start_fall;
  wire auto_start;
  wire go;
  wire core_start_a;
  wire core_start_b;
  wire done_a;
  wire done_b;
  wire [WIDTH-1:0] core_a;
  wire [WIDTH-1:0] core_b;
  wire enabled;
  wire [WIDTH-1:0] sel_word;

  // Start falling edge; strobes of the output side play no part
  assign start_fall = start_q && !i_convert_start_n;
  // Self restart only in power-scaled mode after the acquisition time
  assign auto_start = i_power_scaled && !i_convert_start_n && state == ST_ACQ &&
                      acq_count == ACQ_CYC[7:0] - 8'h01;
  assign go = (state == ST_IDLE || state == ST_ACQ) && (start_fall || auto_start) && !i_power_down;
  // One-cycle kicks; a level start would relaunch a core after its done pulse
  assign core_start_a = kick_a;
  assign core_start_b = kick_b;
  // Outputs are enabled only with both strobes low and reset released
  assign enabled = !i_cs_n && !i_rd_n && !i_rst;
  assign sel_word = i_chan_a_sel ? res_a : res_b;

  // Channel converters share one sequencer, A strictly first
  sar_core #(.WIDTH(WIDTH), .CYCLES(CONV_CYC)) u_core_a (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(core_start_a),
    .i_sample(samp_a),
    .o_done(done_a),
    .o_result(core_a)
  );
  sar_core #(.WIDTH(WIDTH), .CYCLES(CONV_CYC)) u_core_b (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(core_start_b),
    .i_sample(samp_b),
    .o_done(done_b),
    .o_result(core_b)
  );

  // Sequencer next state; once running only completion moves it on
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (go) begin
          next_state = ST_CONV_A;
        end
      end
      ST_CONV_A: begin
        if (done_a) begin
          next_state = ST_CONV_B;
        end
      end
      ST_CONV_B: begin
        if (done_b) begin
          next_state = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (go) begin
          next_state = ST_CONV_A;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Sequencer, sampling, busy and power state
  always @(posedge i_clk) begin
    if (i_rst) begin
      state <= ST_IDLE;
      start_q <= 1'b1;
      acq_count <= 8'h00;
      samp_a <= `SAR_RESULT_RST;
      samp_b <= `SAR_RESULT_RST;
      res_a <= `SAR_RESULT_RST;
      res_b <= `SAR_RESULT_RST;
      o_busy <= 1'b0;
      o_low_power <= 1'b0;
      o_pair_used <= 1'b0;
      kick_a <= 1'b0;
      kick_b <= 1'b0;
    end else begin
      state <= next_state;
      start_q <= i_convert_start_n;
      // A starts with the accepted start, B only once A is done
      kick_a <= go;
      kick_b <= done_a && state == ST_CONV_A;
      if (state == ST_ACQ && acq_count != ACQ_CYC[7:0] - 8'h01) begin
        acq_count <= acq_count + 8'h01;
      end else if (state != ST_ACQ) begin
        acq_count <= 8'h00;
      end
      if (go) begin
        // Both inputs of the chosen pair are held at the same edge
        samp_a <= i_input_pair_select ? i_channel_a_input2 : i_channel_a_input1;
        samp_b <= i_input_pair_select ? i_channel_b_input2 : i_channel_b_input1;
        o_pair_used <= i_input_pair_select;
        o_busy <= 1'b1;
        o_low_power <= 1'b0;
      end else if (done_b) begin
        o_busy <= 1'b0;
        o_low_power <= i_power_scaled || i_power_down;
      end else if (state == ST_IDLE || state == ST_ACQ) begin
        o_low_power <= i_power_scaled || i_power_down;
      end
      // Serial word updates only when both channels are done
      if (done_a && i_serial == 1'b0) begin
        res_a <= core_a;
      end
      if (done_b) begin
        res_a <= core_a;
        res_b <= core_b;
      end
    end
  end

  // Output driver; serial drives only the SDO bus pin, independent of power state
  always @(posedge i_clk) begin
    if (i_rst) begin
      shreg <= {2*WIDTH{1'b0}};
      bits_left <= 6'h00;
      sclk_q <= 1'b0;
      o_data <= {WIDTH{1'b0}};
      o_data_oe <= {WIDTH{1'b0}};
    end else begin
      sclk_q <= i_sclk;
      if (!enabled) begin
        o_data_oe <= {WIDTH{1'b0}};
        bits_left <= 6'h00;
      end else if (!i_serial) begin
        o_data <= sel_word;
        o_data_oe <= {WIDTH{1'b1}};
      end else begin
        o_data_oe <= {WIDTH{1'b0}};
        o_data_oe[`SAR_SDO_BIT] <= 1'b1;
        o_data[`SAR_SCK_BIT] <= 1'b0;
        if (bits_left == 6'h00 && !o_busy) begin
          // First channel chosen by select
          shreg <= i_chan_a_sel ? {res_a, res_b} : {res_b, res_a};
          bits_left <= 6'h20;
          o_data[`SAR_SDO_BIT] <= i_chan_a_sel ? res_a[WIDTH-1] : res_b[WIDTH-1];
        end else if (bits_left != 6'h00 && sclk_q && !i_sclk) begin
          shreg <= {shreg[2*WIDTH-2:0], 1'b0};
          o_data[`SAR_SDO_BIT] <= shreg[2*WIDTH-2];
          bits_left <= bits_left - 6'h01;
        end
      end
    end
  end
endmodule

/* File: verif/sar_ctrl_props.sv */
// Timing checker of the dual-channel conversion controller
`timescale 1ns/1ps
module sar_ctrl_props #(
  parameter WIDTH = 16
) (
  // Watched ports
  input wire i_clk,
  input wire i_rst,
  input wire i_convert_start_n,
  input wire i_power_down,
  input wire i_power_scaled,
  input wire i_input_pair_select,
  input wire i_cs_n,
  input wire i_rd_n,
  input wire o_busy,
  input wire o_low_power,
  input wire o_pair_used,
  input wire [WIDTH-1:0] o_data_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  gate_hiz_a: assert property ((i_cs_n || i_rd_n) |=> o_data_oe == 0)
    else $error("outputs driven while deselected");
  reset_hiz_a: assert property (disable iff (1'b0) i_rst |=> o_data_oe == 0 && !o_busy)
    else $error("bus driven in reset");
  start_take_a: assert property ($fell(i_convert_start_n) && !o_busy && !i_power_down |=> o_busy)
    else $error("start not taken");
  no_abort_a: assert property ($rose(o_busy) |-> ##30 o_busy)
    else $error("conversion cut short");
  busy_end_a: assert property ($rose(o_busy) |-> ##[31:40] !o_busy)
    else $error("busy too long");
  pair_pick_a: assert property ($rose(o_busy) |-> o_pair_used == $past(i_input_pair_select))
    else $error("wrong pair");
  no_auto_a: assert property (!i_power_scaled && !o_busy && !i_convert_start_n && !$past(i_convert_start_n)
    |=> !o_busy)
    else $error("full speed restarted");
  auto_run_a: assert property ($fell(o_busy) && i_power_scaled && !i_convert_start_n |-> ##[5:14] o_busy)
    else $error("no self restart");
  power_cut_a: assert property ($fell(o_busy) && i_power_scaled |-> ##[0:2] o_low_power)
    else $error("power not lowered");
  cover property ($rose(o_busy) && i_power_scaled);
  cover property (!i_cs_n && !i_rd_n && o_busy);
  cover property ($fell(o_busy) && !i_convert_start_n && i_power_scaled);
endmodule
bind sar_ctrl sar_ctrl_props #(.WIDTH(WIDTH)) u_props (.i_clk(i_clk), .i_rst(i_rst),
  .i_convert_start_n(i_convert_start_n), .i_power_down(i_power_down), .i_power_scaled(i_power_scaled),
  .i_input_pair_select(i_input_pair_select), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .o_busy(o_busy),
  .o_low_power(o_low_power), .o_pair_used(o_pair_used), .o_data_oe(o_data_oe));

/* File: verif/sar_host_model.sv */
// Host side model that drives the convert start strobe
`timescale 1ns/1ps
module sar_host_model (
  // Requests from the bench
  input wire logic i_go,
  input wire logic i_hold,
  // Strobe to the converter
  output logic o_convert_start_n
);
  // One-shot start, or held low to keep self-running mode going
  assign o_convert_start_n = !(i_go || i_hold);
endmodule

/* File: verif/testbench.sv */
// Self-checking bench of the dual-channel conversion controller
`timescale 1ns/1ps
module testbench;
  logic clk, rst, go, hold, pd, ps, pair, cs_n, rd_n, a_sel, ser, sclk, start_n, busy, low_pw, pair_used, prev;
  logic [15:0] a1, a2, b1, b2, data, oe;
  logic [31:0] sh;
  int failures = 0, n_compared = 0, cyc = 0, n = 0;
  sar_host_model u_host (.i_go(go), .i_hold(hold), .o_convert_start_n(start_n));
  sar_ctrl u_dut (.i_clk(clk), .i_rst(rst), .i_convert_start_n(start_n), .i_power_down(pd),
    .i_power_scaled(ps), .i_input_pair_select(pair), .i_channel_a_input1(a1), .i_channel_a_input2(a2),
    .i_channel_b_input1(b1), .i_channel_b_input2(b2), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_chan_a_sel(a_sel),
    .i_serial(ser), .i_sclk(sclk), .o_busy(busy), .o_low_power(low_pw), .o_pair_used(pair_used),
    .o_data(data), .o_data_oe(oe));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Bounded wait of 60 cycles so a stuck busy fails the later checks, not a hang
  task automatic wait_idle();
    for (int i = 0; i < 60 && busy; i++) tick(1);
  endtask
  task automatic convert();
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(2);
    check(busy, 1'b1);
    wait_idle();
  endtask
  task automatic read(input logic sel, input logic [15:0] exp);
    a_sel = sel;
    cs_n = 1'b0;
    rd_n = 1'b0;
    tick(2);
    check({oe, data}, {16'hFFFF, exp});
    cs_n = 1'b1;
    rd_n = 1'b1;
    tick(2);
    check(oe, 16'h0000);
  endtask
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  // Cycle ceiling well above the expected run of about 550 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    {rst, go, hold, pd, ps, pair, cs_n, rd_n, a_sel, ser, sclk} = 11'h418;
    {a1, a2, b1, b2} = {16'h1234, 16'hABCD, 16'h5678, 16'hEF01};
    tick(20);
    rst = 1'b0;
    check(oe, 16'h0000);
    for (int p = 0; p < 2; p++) begin
      pair = p[0];
      convert();
      check(pair_used, p[0]);
      read(1'b1, p[0] ? a2 : a1);
      read(1'b0, p[0] ? b2 : b1);
    end
    // Start with strobes low, then power down mid-conversion
    pair = 1'b0;
    a1 = 16'hC3A5;
    read(1'b1, a2);
    cs_n = 1'b0;
    rd_n = 1'b0;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    pd = 1'b1;
    tick(3);
    check(busy, 1'b1);
    wait_idle();
    // Read back while still powered down, so the interface is seen working in low power
    check(low_pw, 1'b1);
    read(1'b1, 16'hC3A5);
    pd = 1'b0;
    hold = 1'b1;
    tick(3);
    check(busy, 1'b1);
    wait_idle();
    tick(20);
    check(busy, 1'b0);
    // Start a real conversion with the bus driven, then reset it away
    hold = 1'b0;
    tick(1);
    {go, cs_n, rd_n} = 3'b100;
    tick(4);
    check({busy, oe}, 17'h1FFFF);
    rst = 1'b1;
    tick(2);
    check({busy, oe}, 17'h0);
    {rst, go} = 2'b00;
    ps = 1'b1;
    hold = 1'b1;
    for (int i = 0; i < 200; i++) begin
      prev = busy;
      tick(1);
      n += busy && !prev;
      if (!busy && !prev) check(low_pw, 1'b1);
    end
    check(n >= 4, 1'b1);
    {hold, ps, ser, a_sel, cs_n, rd_n} = 6'h3C;
    wait_idle();
    tick(3);
    for (int i = 0; i < 32; i++) begin
      sh = {sh[30:0], data[0]};
      sclk = 1'b1;
      tick(1);
      sclk = 1'b0;
      tick(2);
    end
    check(sh, {16'hC3A5, b1});
    end_sim();
  end
endmodule
